// File: rtl/adcmap_spi_regs.sv
// Serial control port and register map of the dual converter
//
// Function
// - Every register location holds eight bits, bit 7 most significant.
// - The map decodes config at 0x00-0x02, channel index 0x05, transfer 0xFF, setup 0x08-0x30 and 0x100.
// - Registers 0x08 to 0x18 and 0x30 keep written values in a shadow stage without changing operation.
// - Writing 0x01 to 0xFF copies every shadow value to its active register at once.
// - The transfer bit clears itself after the copy so it reads back as zero.
// - Local registers exist once per channel and are routed by the two select bits at 0x05.
// - With both select bits set a local write updates both channel copies.
// - A local read with both select bits set returns channel A.
// - Global registers are single copies and ignore the select bits.
// - Any reset loads the documented defaults into the registers, except that soft reset keeps the bit order at 0x00.
// - The reference select register resets to 0xC0.
// - A frame starts with a 16-bit instruction holding read flag and word count, then bytes, data pin turns for reads.
// - The port shifts most significant bit first until the port setup selects the other order.
`timescale 1ns/1ps
`default_nettype none
`include "adcmap_regs.svh"
module adcmap_spi_regs #(
  parameter logic [7:0] PART_ID_CODE = 8'hA5,  // Arbitrary value
  parameter logic [1:0] SPEED_GRADE  = 2'h0
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic                       serial_clock,
  input  wire logic                       port_select_n,
  input  wire logic                       sdio_in,
  output var  logic                       sdio_out,
  output var  logic                       sdio_oe_n,
  output var  adcmap_pkg::adcmap_active_s active_settings
);

  localparam int         NSLOT     = 7;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [12:0] OPEN_ADDR = 13'h0013;

  // ****************************************************************************
  // Decode helpers
  // ****************************************************************************
  function automatic logic [2:0] slot_of(input logic [12:0] a);
    case (a)
      `ADCMAP_ADDR_PWR:  slot_of = 3'h0;
      `ADCMAP_ADDR_GCLK: slot_of = 3'h1;
      `ADCMAP_ADDR_CDIV: slot_of = 3'h2;
      `ADCMAP_ADDR_TEST: slot_of = 3'h3;
      `ADCMAP_ADDR_VREF: slot_of = 3'h4;
      `ADCMAP_ADDR_AUX:  slot_of = 3'h5;
      `ADCMAP_ADDR_DIGI: slot_of = 3'h6;
      default:           slot_of = SLOT_NONE;
    endcase
  endfunction : slot_of

  function automatic bit slot_local(input int s);
    slot_local = (s == 0) || (s == 3);
  endfunction : slot_local

  function automatic logic [7:0] slot_rst(input int s);
    case (s)
      0:       slot_rst = `ADCMAP_RST_PWR;
      1:       slot_rst = `ADCMAP_RST_GCLK;
      2:       slot_rst = `ADCMAP_RST_CDIV;
      3:       slot_rst = `ADCMAP_RST_TEST;
      4:       slot_rst = `ADCMAP_RST_VREF;
      5:       slot_rst = `ADCMAP_RST_AUX;
      default: slot_rst = `ADCMAP_RST_DIGI;
    endcase
  endfunction : slot_rst

  function automatic logic [7:0] slot_mask(input int s);
    case (s)
      0:       slot_mask = `ADCMAP_MASK_PWR;
      1:       slot_mask = `ADCMAP_MASK_GCLK;
      2:       slot_mask = `ADCMAP_MASK_CDIV;
      3:       slot_mask = `ADCMAP_MASK_TEST;
      4:       slot_mask = `ADCMAP_MASK_VREF;
      5:       slot_mask = `ADCMAP_MASK_AUX;
      default: slot_mask = `ADCMAP_MASK_DIGI;
    endcase
  endfunction : slot_mask

  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = x[7-i];
    end
  endfunction : rev8

  // ****************************************************************************
  // Pin sampling
  // ****************************************************************************
  adcmap_pkg::adcmap_pins_s pins_raw;
  adcmap_pkg::adcmap_pins_s pins_q;
  logic                     sclk_prev_reg;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     deselected;

  assign pins_raw = '{serial_clock: serial_clock, port_select_n: port_select_n, data_in: sdio_in};

  adcmap_sync #(
    .WIDTH (3),
    .IDLE  (`ADCMAP_PINS_IDLE)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pins_raw),
    .filt_q   (pins_q)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sclk_prev_reg <= pins_q.serial_clock;
    end
  end

  assign sclk_rise  = pins_q.serial_clock & ~sclk_prev_reg;
  assign sclk_fall  = ~pins_q.serial_clock & sclk_prev_reg;
  assign deselected = pins_q.port_select_n;

  // ****************************************************************************
  // Frame engine
  // ****************************************************************************
  adcmap_pkg::adcmap_state_e state_reg;
  logic [4:0]                bit_cnt_reg;
  logic [15:0]               shift_reg;
  logic [15:0]               shift_next;
  logic [15:0]               instr_word;
  logic                      is_read_reg;
  logic                      stream_reg;
  logic [1:0]                words_left_reg;
  logic [12:0]               addr_reg;
  logic [12:0]               addr_step;
  logic [12:0]               rd_addr;
  logic [7:0]                rd_data;
  logic [7:0]                tx_reg;
  logic [2:0]                tx_idx_reg;
  logic                      lsb_first_reg;
  logic                      byte_done;
  logic                      wr_en;
  logic [12:0]               wr_addr;
  logic [7:0]                wr_data;

  assign shift_next = {shift_reg[14:0], pins_q.data_in};
  // Arrival order is reversed in low-first mode
  assign instr_word = lsb_first_reg ? {rev8(shift_next[7:0]), rev8(shift_next[15:8])} : shift_next;
  assign addr_step  = lsb_first_reg ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
  assign rd_addr    = (state_reg == adcmap_pkg::ST_INSTR) ? instr_word[12:0] : addr_step;
  assign byte_done  = (state_reg == adcmap_pkg::ST_DATA) && sclk_rise && (bit_cnt_reg == `ADCMAP_BYTE_LAST);
  assign wr_en      = clk_en && !deselected && byte_done && !is_read_reg;
  assign wr_addr    = addr_reg;
  assign wr_data    = lsb_first_reg ? rev8(shift_next[7:0]) : shift_next[7:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg      <= adcmap_pkg::ST_IDLE;
      bit_cnt_reg    <= 5'h00;
      shift_reg      <= 16'h0000;
      is_read_reg    <= 1'b0;
      stream_reg     <= 1'b0;
      words_left_reg <= 2'h0;
      addr_reg       <= 13'h0000;
    end else if (clk_en) begin
      if (deselected) begin
        state_reg <= adcmap_pkg::ST_IDLE;
      end else begin
        case (state_reg)
          adcmap_pkg::ST_IDLE: begin
            state_reg   <= adcmap_pkg::ST_INSTR;
            bit_cnt_reg <= 5'h00;
          end
          adcmap_pkg::ST_INSTR: begin
            if (sclk_rise) begin
              shift_reg   <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `ADCMAP_INSTR_BITS - 5'h01) begin
                bit_cnt_reg    <= 5'h00;
                is_read_reg    <= instr_word[`ADCMAP_INSTR_RW];
                words_left_reg <= instr_word[`ADCMAP_INSTR_W_HI:`ADCMAP_INSTR_W_LO];
                stream_reg     <= instr_word[`ADCMAP_INSTR_W_HI:`ADCMAP_INSTR_W_LO] == `ADCMAP_WORDS_STREAM;
                addr_reg       <= instr_word[12:0];
                state_reg      <= adcmap_pkg::ST_DATA;
              end
            end
          end
          adcmap_pkg::ST_DATA: begin
            if (sclk_rise) begin
              shift_reg   <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (byte_done) begin
                bit_cnt_reg    <= 5'h00;
                addr_reg       <= addr_step;
                words_left_reg <= words_left_reg - 2'h1;
                if (!stream_reg && words_left_reg == 2'h0) begin
                  state_reg <= adcmap_pkg::ST_DONE;
                end
              end
            end
          end
          adcmap_pkg::ST_DONE: begin
            state_reg <= adcmap_pkg::ST_DONE;
          end
          default: begin
            state_reg <= adcmap_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Read data is launched on falling edges so it is stable at the host's rising edge
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_reg     <= 8'h00;
      tx_idx_reg <= 3'h0;
      sdio_out   <= 1'b0;
      sdio_oe_n  <= 1'b1;
    end else if (clk_en) begin
      if (deselected) begin
        sdio_oe_n <= 1'b1;
      end else if (state_reg == adcmap_pkg::ST_INSTR && sclk_rise && bit_cnt_reg == `ADCMAP_INSTR_BITS - 5'h01) begin
        tx_reg     <= rd_data;
        tx_idx_reg <= 3'h0;
      end else if (byte_done && is_read_reg) begin
        tx_reg     <= rd_data;
        tx_idx_reg <= 3'h0;
      end else if (state_reg == adcmap_pkg::ST_DATA && is_read_reg && sclk_fall) begin
        sdio_out   <= lsb_first_reg ? tx_reg[tx_idx_reg] : tx_reg[3'h7 - tx_idx_reg];
        sdio_oe_n  <= 1'b0;
        tx_idx_reg <= tx_idx_reg + 3'h1;
      end
    end
  end

  // ****************************************************************************
  // Chip configuration, channel index and transfer
  // ****************************************************************************
  logic       soft_rst_reg;
  logic       reg_rst;
  logic [1:0] chan_sel_reg;
  logic       transfer_reg;

  assign reg_rst = rst | soft_rst_reg;

  // Soft reset leaves the bit order alone so the host keeps its link
  always_ff @(posedge clock) begin
    if (rst) begin
      lsb_first_reg <= 1'b0;
      soft_rst_reg  <= 1'b0;
    end else if (clk_en) begin
      soft_rst_reg <= 1'b0;
      if (wr_en && wr_addr == `ADCMAP_ADDR_PORT) begin
        lsb_first_reg <= wr_data[`ADCMAP_PORT_LSB_HI] | wr_data[`ADCMAP_PORT_LSB_LO];
        soft_rst_reg  <= wr_data[`ADCMAP_PORT_SRST_HI] | wr_data[`ADCMAP_PORT_SRST_LO];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reg_rst) begin
      chan_sel_reg <= `ADCMAP_RST_CHAN;
    end else if (clk_en && wr_en && wr_addr == `ADCMAP_ADDR_CHAN) begin
      chan_sel_reg <= wr_data[1:0];
    end
  end

  // A new transfer write wins over the self-clear
  always_ff @(posedge clock) begin
    if (reg_rst) begin
      transfer_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && wr_addr == `ADCMAP_ADDR_XFER && wr_data[`ADCMAP_XFER_BIT]) begin
        transfer_reg <= 1'b1;
      end else if (transfer_reg) begin
        transfer_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************************
  // Setup registers
  // ****************************************************************************
  logic [7:0] shadow_q [NSLOT][2];
  logic [7:0] active_q [NSLOT][2];

  genvar s;
  genvar c;
  generate
    for (s = 0; s < NSLOT; s = s + 1) begin : g_slot
      for (c = 0; c < 2; c = c + 1) begin : g_chan
        if (c == 0 || slot_local(s)) begin : g_cell
          logic sel;
          // Global copies ignore the select bits
          assign sel = slot_local(s) ? chan_sel_reg[c] : 1'b1;
          adcmap_regcell #(
            .RESET_VALUE (slot_rst(s)),
            .MASK        (slot_mask(s)),
            .SHADOWED    (s != 6)
          ) u_cell (
            .clock    (clock),
            .rst      (reg_rst),
            .clk_en   (clk_en),
            .wr_en    (wr_en && slot_of(wr_addr) == 3'(s) && sel),
            .wr_data  (wr_data),
            .commit   (transfer_reg),
            .shadow_q (shadow_q[s][c]),
            .active_q (active_q[s][c])
          );
        end else begin : g_alias
          assign shadow_q[s][c] = shadow_q[s][0];
          assign active_q[s][c] = active_q[s][0];
        end
      end
    end
  endgenerate

  assign active_settings = {active_q[0][0], active_q[0][1], active_q[1][0], active_q[2][0],
                            active_q[3][0], active_q[3][1], active_q[4][0], active_q[5][0], active_q[6][0]};

  // ****************************************************************************
  // Read-back
  // ****************************************************************************
  always_comb begin
    logic [2:0] rs;
    rs      = slot_of(rd_addr);
    rd_data = 8'h00;
    case (rd_addr)
      `ADCMAP_ADDR_PORT:    rd_data = `ADCMAP_PORT_FIXED | {1'b0, lsb_first_reg, 4'h0, lsb_first_reg, 1'b0};
      `ADCMAP_ADDR_PART_ID: rd_data = PART_ID_CODE;
      `ADCMAP_ADDR_GRADE:   rd_data = {2'h0, SPEED_GRADE, 4'h0};
      `ADCMAP_ADDR_CHAN:    rd_data = {6'h00, chan_sel_reg};
      `ADCMAP_ADDR_XFER:    rd_data = {7'h00, transfer_reg};
      default: begin
        if (rs != SLOT_NONE) begin
          // Channel B only when B alone is selected
          rd_data = (chan_sel_reg == 2'h2) ? shadow_q[rs][1] : shadow_q[rs][0];
        end
      end
    endcase
  end

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  transfer_clear_a: assert property (transfer_reg && clk_en |=> !transfer_reg)
    else $error("transfer bit did not clear");
  commit_copy_a: assert property (transfer_reg && clk_en && !soft_rst_reg
    |=> active_q[4][0] == $past(shadow_q[4][0]))
    else $error("commit did not copy shadow");
  shadow_hold_a: assert property (!transfer_reg && !soft_rst_reg |=> $stable(active_q[0][1]))
    else $error("active changed without commit");
  reset_default_a: assert property ($fell(rst) |-> shadow_q[4][0] == `ADCMAP_RST_VREF
    && active_q[0][0] == `ADCMAP_RST_PWR && !lsb_first_reg)
    else $error("reset defaults wrong");
  both_write_a: assert property (wr_en && chan_sel_reg == 2'h3 && wr_addr == `ADCMAP_ADDR_TEST && !soft_rst_reg
    |=> shadow_q[3][0] == shadow_q[3][1])
    else $error("both-channel write differs");
  read_chan_a: assert property (chan_sel_reg == 2'h3 && rd_addr == `ADCMAP_ADDR_PWR
    |-> rd_data == shadow_q[0][0])
    else $error("dual select read not channel A");
  global_write_a: assert property (wr_en && wr_addr == `ADCMAP_ADDR_GCLK && !soft_rst_reg
    |=> shadow_q[1][0] == ($past(wr_data) & `ADCMAP_MASK_GCLK))
    else $error("global write lost");
  open_read_a: assert property (rd_addr == OPEN_ADDR |-> rd_data == 8'h00)
    else $error("open address reads nonzero");
  drive_read_a: assert property (!sdio_oe_n |-> is_read_reg && !$past(deselected))
    else $error("data pin driven outside read");

  commit_seen_c: cover property (transfer_reg ##1 !transfer_reg);
  read_frame_c: cover property ($fell(sdio_oe_n));
  dual_write_c: cover property (wr_en && chan_sel_reg == 2'h3);
  lsb_mode_c: cover property ($rose(lsb_first_reg));

endmodule : adcmap_spi_regs
`default_nettype wire

// File: shared/adcmap_regs.svh
// Register offsets, field positions and reset values of the converter control map
`ifndef ADCMAP_REGS_SVH
`define ADCMAP_REGS_SVH

// ****************************************************************************
// Serial frame layout
// ****************************************************************************
`define ADCMAP_INSTR_BITS   5'h10
`define ADCMAP_INSTR_RW     15
`define ADCMAP_INSTR_W_HI   14
`define ADCMAP_INSTR_W_LO   13
`define ADCMAP_ADDR_W       13
`define ADCMAP_BYTE_LAST    5'h07
`define ADCMAP_WORDS_STREAM 2'h3

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define ADCMAP_ADDR_PORT    13'h0000
`define ADCMAP_ADDR_PART_ID 13'h0001
`define ADCMAP_ADDR_GRADE   13'h0002
`define ADCMAP_ADDR_CHAN    13'h0005
`define ADCMAP_ADDR_XFER    13'h00FF
`define ADCMAP_ADDR_PWR     13'h0008
`define ADCMAP_ADDR_GCLK    13'h0009
`define ADCMAP_ADDR_CDIV    13'h000B
`define ADCMAP_ADDR_TEST    13'h000D
`define ADCMAP_ADDR_VREF    13'h0018
`define ADCMAP_ADDR_AUX     13'h0030
`define ADCMAP_ADDR_DIGI    13'h0100

// ****************************************************************************
// Field positions
// ****************************************************************************
`define ADCMAP_PORT_LSB_HI  6
`define ADCMAP_PORT_LSB_LO  1
`define ADCMAP_PORT_SRST_HI 5
`define ADCMAP_PORT_SRST_LO 2
`define ADCMAP_PORT_FIXED   8'h18
`define ADCMAP_XFER_BIT     0
`define ADCMAP_CHAN_A_BIT   0
`define ADCMAP_CHAN_B_BIT   1
`define ADCMAP_GRADE_POS    4

// ****************************************************************************
// Reset values and writable bit masks
// ****************************************************************************
`define ADCMAP_RST_CHAN     2'h3
`define ADCMAP_RST_PWR      8'h80
`define ADCMAP_RST_GCLK     8'h01
`define ADCMAP_RST_CDIV     8'h00
`define ADCMAP_RST_TEST     8'h00
`define ADCMAP_RST_VREF     8'hC0
`define ADCMAP_RST_AUX      8'h00
`define ADCMAP_RST_DIGI     8'h00
`define ADCMAP_MASK_PWR     8'hA3
`define ADCMAP_MASK_GCLK    8'h01
`define ADCMAP_MASK_CDIV    8'h07
`define ADCMAP_MASK_TEST    8'h37
`define ADCMAP_MASK_VREF    8'hC0
`define ADCMAP_MASK_AUX     8'hFF
`define ADCMAP_MASK_DIGI    8'hFF
`define ADCMAP_PINS_IDLE    3'h2

`endif

// File: shared/adcmap_pkg.sv
// Types shared by the converter control map modules
`default_nettype none
package adcmap_pkg;

  typedef logic [7:0] adcmap_byte_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA,
    ST_DONE
  } adcmap_state_e;

  typedef struct packed {
    logic serial_clock;
    logic port_select_n;
    logic data_in;
  } adcmap_pins_s;

  typedef struct packed {
    adcmap_byte_t power_a;
    adcmap_byte_t power_b;
    adcmap_byte_t global_clock;
    adcmap_byte_t clock_divide;
    adcmap_byte_t test_a;
    adcmap_byte_t test_b;
    adcmap_byte_t vref_select;
    adcmap_byte_t aux_setup;
    adcmap_byte_t digital_feature;
  } adcmap_active_s;

endpackage : adcmap_pkg
`default_nettype wire

// File: rtl/adcmap_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module adcmap_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] filt_q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else if (clk_en) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once two settled stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clock) begin
        if (rst) begin
          filt_q[i] <= IDLE[i];
        end else if (clk_en && (s2_reg[i] == s3_reg[i])) begin
          filt_q[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

endmodule : adcmap_sync
`default_nettype wire

// File: rtl/adcmap_regcell.sv
// One 8-bit setup register with optional shadow stage
`timescale 1ns/1ps
`default_nettype none
module adcmap_regcell #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] MASK        = 8'hFF,
  parameter bit         SHADOWED    = 1'b1
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       commit,
  output var  logic [7:0] shadow_q,
  output var  logic [7:0] active_q
);

  // Unsupported bits never store anything
  always_ff @(posedge clock) begin
    if (rst) begin
      shadow_q <= RESET_VALUE;
    end else if (clk_en && wr_en) begin
      shadow_q <= wr_data & MASK;
    end
  end

  // Shadowed cells only move on commit, so the part sees all changes at once
  always_ff @(posedge clock) begin
    if (rst) begin
      active_q <= RESET_VALUE;
    end else if (clk_en) begin
      if (SHADOWED && commit) begin
        active_q <= shadow_q;
      end else if (!SHADOWED && wr_en) begin
        active_q <= wr_data & MASK;
      end
    end
  end

endmodule : adcmap_regcell
`default_nettype wire

// File: tb/adcmap_host.sv
// Serial host model that drives the converter control port
`timescale 1ns/1ps
`default_nettype none
module adcmap_host (
  input  wire logic clock,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  output var  logic serial_clock,
  output var  logic port_select_n,
  output wire logic sdio_in
);
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  // Set by the bench once the port is switched to low-first order
  logic lsb = 1'b0;
  initial serial_clock = 1'b0;
  initial port_select_n = 1'b1;
  // No pull on the line: when released it shows the inverse of the last bit
  assign sdio_in = !sdio_oe_n ? sdio_out : (drv ? bit_q : !bit_q);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk

  // One-byte frame; serial clock idles low outside frames
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, 2'h0, a, wd};
    q = 8'h00;
    @(posedge clock);
    port_select_n <= 1'b0;
    drv <= 1'b1;
    wait_clk(12);
    for (int i = 23; i >= 0; i--) begin
      int k;
      k = !lsb ? i : ((i >= 8) ? 31 - i : 7 - i);
      serial_clock <= 1'b0;
      drv <= !(rd && i < 8);
      bit_q <= sh[k];
      wait_clk(12);
      if (i < 8) q[k] = sdio_in;
      serial_clock <= 1'b1;
      wait_clk(13);
    end
    serial_clock <= 1'b0;
    wait_clk(12);
    port_select_n <= 1'b1;
    drv <= 1'b1;
    wait_clk(12);
  endtask : xfer
endmodule : adcmap_host
`default_nettype wire

// File: tb/adcmap_spi_regs_tb_top.sv
// Self-checking bench for the converter control map
`timescale 1ns/1ps
`default_nettype none
module adcmap_spi_regs_tb_top;
  logic                       clock = 1'b0;
  logic                       rst = 1'b1;
  logic                       clk_en = 1'b0;
  logic                       sck, sel_n, sdi, sdo, oe_n;
  logic [7:0]                 q;
  adcmap_pkg::adcmap_active_s act;
  int                         fail_count = 0;
  int                         check_count = 0;
  always #2.5 clock = ~clock;

  // Identification value is arbitrary
  adcmap_spi_regs #(.PART_ID_CODE(8'h5A), .SPEED_GRADE(2'h2)) u_adcmap_spi_regs (.clock(clock), .rst(rst),
    .clk_en(clk_en), .serial_clock(sck), .port_select_n(sel_n), .sdio_in(sdi), .sdio_out(sdo),
    .sdio_oe_n(oe_n), .active_settings(act));
  adcmap_host u_adcmap_host (.clock(clock), .sdio_out(sdo), .sdio_oe_n(oe_n), .serial_clock(sck),
    .port_select_n(sel_n), .sdio_in(sdi));

  // ***************************************************************************
  // Compare and access tasks
  // ***************************************************************************
  task automatic chk_set(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_set
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    chk_set({64'h0, got}, {64'h0, exp});
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_adcmap_host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    u_adcmap_host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #250us;
    fail_count++;
    finish_test();
  end

  // ***************************************************************************
  // Tests
  // ***************************************************************************
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    clk_en <= 1'b1;
    repeat (8) @(posedge clock);
    chk_set(act, 72'h80_80_01_00_00_00_C0_00_00);
    rd(13'h018, 8'hC0);
    rd(13'h000, 8'h18);
    rd(13'h001, 8'h5A);
    rd(13'h002, 8'h20);
    rd(13'h013, 8'h00);
    $display("test defaults done");
    wr(13'h018, 8'h40);
    rd(13'h018, 8'h40);
    chk(act.vref_select, 8'hC0);
    wr(13'h0FF, 8'h01);
    chk(act.vref_select, 8'h40);
    rd(13'h0FF, 8'h00);
    $display("test shadow done");
    wr(13'h005, 8'h01);
    wr(13'h008, 8'h01);
    wr(13'h005, 8'h02);
    wr(13'h008, 8'h02);
    rd(13'h008, 8'h02);
    wr(13'h00B, 8'h03);
    wr(13'h009, 8'h00);
    rd(13'h00B, 8'h03);
    wr(13'h005, 8'h03);
    rd(13'h008, 8'h01);
    wr(13'h00D, 8'h05);
    wr(13'h0FF, 8'h01);
    chk(act.power_a, 8'h01);
    chk(act.power_b, 8'h02);
    chk(act.test_a, 8'h05);
    chk(act.test_b, 8'h05);
    chk(act.clock_divide, 8'h03);
    chk(act.global_clock, 8'h00);
    wr(13'h100, 8'h3C);
    chk(act.digital_feature, 8'h3C);
    $display("test channels done");
    wr(13'h000, 8'h42);
    u_adcmap_host.lsb = 1'b1;
    rd(13'h000, 8'h5A);
    wr(13'h018, 8'h80);
    rd(13'h018, 8'h80);
    wr(13'h000, 8'h00);
    u_adcmap_host.lsb = 1'b0;
    rd(13'h000, 8'h18);
    $display("test bit order done");
    clk_en <= 1'b0;
    wr(13'h030, 8'h11);
    clk_en <= 1'b1;
    rd(13'h030, 8'h00);
    wr(13'h030, 8'h11);
    chk(act.aux_setup, 8'h00);
    wr(13'h0FF, 8'h01);
    chk(act.aux_setup, 8'h11);
    wr(13'h000, 8'h24);
    chk_set(act, 72'h80_80_01_00_00_00_C0_00_00);
    rd(13'h005, 8'h03);
    rd(13'h018, 8'hC0);
    $display("test freeze and soft reset done");
    finish_test();
  end
endmodule : adcmap_spi_regs_tb_top
`default_nettype wire
